// ---- verilog/dcec_defs.svh ----
/*
 * offsets, field positions, reset values for the dma channel event control.
 * assumes inclusion by bare name from the design files only.
 */
`ifndef DCEC_DEFS_SVH
`define DCEC_DEFS_SVH

`define DCEC_OFF_EVENT_CONTROL 4'h0
`define DCEC_OFF_STATUS 4'h1
`define DCEC_OFF_IRQ_STATUS 4'h2
`define DCEC_OFF_IRQ_CLEAR 4'h3
`define DCEC_OFF_IRQ_ENABLE 4'h4

`define DCEC_ABORT_SEL_HI 23
`define DCEC_ABORT_SEL_LO 16
`define DCEC_START_SEL_HI 15
`define DCEC_START_SEL_LO 8
`define DCEC_BIT_FORCE 7
`define DCEC_BIT_SW_ABORT 6
`define DCEC_BIT_PAT_EN 5
`define DCEC_BIT_START_EN 4
`define DCEC_BIT_ABORT_EN 3

`define DCEC_SEL_RESET 8'hFF
`define DCEC_EN_RESET 1'h0

`define DCEC_EV_START 0
`define DCEC_EV_ABORT 1
`define DCEC_EV_PATTERN 2
`define DCEC_EV_WIDTH 3

`endif

// ---- verilog/dcec_pkg.sv ----
/*
 * types shared by the dma channel event control files.
 * assumes nothing beyond a systemverilog compiler.
 */
package dcec_pkg;
    typedef struct packed {
        logic [7:0] abort_request_select;
        logic [7:0] start_request_select;
        logic pattern_abort_enable;
        logic start_request_enable;
        logic abort_request_enable;
    } dcec_ctrl_s;

    typedef struct packed {
        logic start;
        logic abort;
        logic disable_channel;
    } dcec_cmd_s;

    typedef enum logic [1:0] {
        DCEC_IDLE,
        DCEC_BUSY
    } dcec_state_e;
endpackage

// ---- verilog/dcec_irq_match.sv ----
/*
 * irq match: flags whether the selected request line fires this cycle.
 * assumes irq lines already synchronised to clk.
 */
`timescale 1ns/1ps
module dcec_irq_match #(
    parameter int NUM_IRQ = 256
) (
    input wire logic [NUM_IRQ-1:0] irq,
    input wire logic [7:0] sel,
    input wire logic enable,
    output logic hit
);
    wire selected_line;

    // selector beyond the line count never matches
    assign selected_line = (32'(sel) < NUM_IRQ) ? irq[sel] : 1'b0;
    assign hit = enable & selected_line;
endmodule

// ---- verilog/dcec_event_control.sv ----
/*
 * dma channel event control: start/abort triggers for one dma channel.
 * assumes irq lines from another domain, engine on clk, simple reg port.
 */
`timescale 1ns/1ps
`include "dcec_defs.svh"
module dcec_event_control #(
    parameter int NUM_IRQ = 256
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_IRQ-1:0] irq_lines,
    input wire logic pattern_match,
    input wire logic channel_enable,
    input wire logic transfer_done,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic start_transfer,
    output logic abort_transfer,
    output logic clear_channel_enable,
    output logic transfer_active,
    output logic channel_abort_flag,
    output logic irq
);
    dcec_pkg::dcec_ctrl_s ctrl_r;
    dcec_pkg::dcec_cmd_s cmd_r;
    dcec_pkg::dcec_state_e state_r;
    dcec_pkg::dcec_state_e state_nxt;
    logic [NUM_IRQ-1:0] irq_meta_r;
    logic [NUM_IRQ-1:0] irq_sync_r;
    logic [NUM_IRQ-1:0] irq_prev_r;
    logic [1:0] pat_sync_r;
    logic abort_flag_r;
    logic [`DCEC_EV_WIDTH-1:0] ev_status_r;
    logic [`DCEC_EV_WIDTH-1:0] ev_enable_r;
    logic [31:0] rdata_r;

    function automatic logic is_wr(input logic [3:0] a, input logic [3:0] o,
                                   input logic w);
        return w && (a == o);
    endfunction

    // edge-detect irqs so a held line triggers once
    wire [NUM_IRQ-1:0] irq_rise = irq_sync_r & ~irq_prev_r;
    wire start_hit;
    wire abort_hit;

    dcec_irq_match #(.NUM_IRQ(NUM_IRQ)) u_start_match (
        .irq(irq_rise),
        .sel(ctrl_r.start_request_select),
        .enable(ctrl_r.start_request_enable),
        .hit(start_hit)
    );

    dcec_irq_match #(.NUM_IRQ(NUM_IRQ)) u_abort_match (
        .irq(irq_rise),
        .sel(ctrl_r.abort_request_select),
        .enable(ctrl_r.abort_request_enable),
        .hit(abort_hit)
    );

    wire ctrl_wr = is_wr(reg_addr, `DCEC_OFF_EVENT_CONTROL, reg_write);
    wire clr_wr = is_wr(reg_addr, `DCEC_OFF_IRQ_CLEAR, reg_write);
    wire en_wr = is_wr(reg_addr, `DCEC_OFF_IRQ_ENABLE, reg_write);
    wire force_req = ctrl_wr & reg_wdata[`DCEC_BIT_FORCE];
    wire sw_abort_req = ctrl_wr & reg_wdata[`DCEC_BIT_SW_ABORT];
    wire pat_hit = ctrl_r.pattern_abort_enable & pat_sync_r[1];
    wire pat_abort = pat_hit & (state_r == dcec_pkg::DCEC_BUSY);
    wire any_abort = abort_hit | sw_abort_req | pat_abort;
    wire any_start = start_hit | force_req;
    // abort wins a tie; starting is suppressed the same cycle
    wire do_start = any_start & ~any_abort & channel_enable;
    wire do_abort = any_abort & (state_r == dcec_pkg::DCEC_BUSY);
    wire [`DCEC_EV_WIDTH-1:0] ev_set;

    assign ev_set[`DCEC_EV_START] = do_start;
    assign ev_set[`DCEC_EV_ABORT] = abort_hit;
    assign ev_set[`DCEC_EV_PATTERN] = pat_hit;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dcec_pkg::DCEC_IDLE: begin
                if (do_start) begin
                    state_nxt = dcec_pkg::DCEC_BUSY;
                end
            end
            dcec_pkg::DCEC_BUSY: begin
                // a fresh start beside done keeps the channel busy
                if ((any_abort || transfer_done || !channel_enable)
                    && !do_start) begin
                    state_nxt = dcec_pkg::DCEC_IDLE;
                end
            end
            default: state_nxt = dcec_pkg::DCEC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_meta_r <= '0;
            irq_sync_r <= '0;
            irq_prev_r <= '0;
            pat_sync_r <= 2'h0;
        end else begin
            irq_meta_r <= irq_lines;
            irq_sync_r <= irq_meta_r;
            irq_prev_r <= irq_sync_r;
            pat_sync_r <= {pat_sync_r[0], pattern_match};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r.abort_request_select <= `DCEC_SEL_RESET;
            ctrl_r.start_request_select <= `DCEC_SEL_RESET;
            ctrl_r.pattern_abort_enable <= `DCEC_EN_RESET;
            ctrl_r.start_request_enable <= `DCEC_EN_RESET;
            ctrl_r.abort_request_enable <= `DCEC_EN_RESET;
        end else if (ctrl_wr) begin
            // only implemented fields are stored
            ctrl_r.abort_request_select <=
                reg_wdata[`DCEC_ABORT_SEL_HI:`DCEC_ABORT_SEL_LO];
            ctrl_r.start_request_select <=
                reg_wdata[`DCEC_START_SEL_HI:`DCEC_START_SEL_LO];
            ctrl_r.pattern_abort_enable <= reg_wdata[`DCEC_BIT_PAT_EN];
            ctrl_r.start_request_enable <= reg_wdata[`DCEC_BIT_START_EN];
            ctrl_r.abort_request_enable <= reg_wdata[`DCEC_BIT_ABORT_EN];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= dcec_pkg::DCEC_IDLE;
            cmd_r <= '0;
        end else begin
            state_r <= state_nxt;
            cmd_r.start <= do_start;
            cmd_r.abort <= do_abort;
            cmd_r.disable_channel <= pat_hit;
        end
    end

    // abort flag: set by irq abort, cleared through the irq clear register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            abort_flag_r <= 1'b0;
        end else if (abort_hit) begin
            abort_flag_r <= 1'b1;
        end else if (clr_wr && reg_wdata[`DCEC_EV_ABORT]) begin
            abort_flag_r <= 1'b0;
        end
    end

    // sticky events: set beats clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ev_status_r <= '0;
            ev_enable_r <= '0;
        end else begin
            ev_status_r <= ev_set |
                (ev_status_r & ~(clr_wr ? reg_wdata[`DCEC_EV_WIDTH-1:0] : '0));
            if (en_wr) begin
                ev_enable_r <= reg_wdata[`DCEC_EV_WIDTH-1:0];
            end
        end
    end

    wire [31:0] ctrl_view;
    wire [31:0] status_view;
    wire [31:0] read_mux;

    // force and abort bits are one-shot, never stored
    assign ctrl_view = {8'h00,
                        ctrl_r.abort_request_select,
                        ctrl_r.start_request_select,
                        1'b0,
                        1'b0,
                        ctrl_r.pattern_abort_enable,
                        ctrl_r.start_request_enable,
                        ctrl_r.abort_request_enable,
                        3'h0};
    assign status_view = {30'h0, abort_flag_r,
                          state_r == dcec_pkg::DCEC_BUSY};
    assign read_mux =
        (reg_addr == `DCEC_OFF_EVENT_CONTROL) ? ctrl_view :
        (reg_addr == `DCEC_OFF_STATUS) ? status_view :
        (reg_addr == `DCEC_OFF_IRQ_STATUS) ?
            {{(32-`DCEC_EV_WIDTH){1'b0}}, ev_status_r} :
        (reg_addr == `DCEC_OFF_IRQ_ENABLE) ?
            {{(32-`DCEC_EV_WIDTH){1'b0}}, ev_enable_r} :
        32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_read) begin
            rdata_r <= read_mux;
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_r;
    assign start_transfer = cmd_r.start;
    assign abort_transfer = cmd_r.abort;
    assign clear_channel_enable = cmd_r.disable_channel;
    assign transfer_active = (state_r == dcec_pkg::DCEC_BUSY);
    assign channel_abort_flag = abort_flag_r;
    assign irq = |(ev_status_r & ev_enable_r);
endmodule

// ---- tb/dcec_checker.sv ----
/* checker: port timing of the event control.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module dcec_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic channel_enable,
    input wire logic start_transfer,
    input wire logic abort_transfer,
    input wire logic clear_channel_enable,
    input wire logic transfer_active,
    input wire logic channel_abort_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire ctl_wr = reg_write && reg_addr == 4'h0;
    wire flag_clr = reg_write && reg_addr == 4'h3 && reg_wdata[1];
    // a same-cycle irq abort may win, which then shows in the flag
    a_force_start: assert property (ctl_wr && reg_wdata[7:6] == 2'h2
        && channel_enable && !transfer_active
        |=> start_transfer || channel_abort_flag) else $error("no start");
    a_abort_wins: assert property (ctl_wr && reg_wdata[7:6] == 2'h3
        |=> !start_transfer && !transfer_active) else $error("start won");
    a_sw_abort: assert property (ctl_wr && reg_wdata[6] && transfer_active
        |=> abort_transfer && !transfer_active) else $error("no abort");
    a_abort_ends: assert property (abort_transfer
        |-> $past(transfer_active) && !transfer_active) else $error("abort");
    a_start_pulse: assert property (start_transfer
        |-> transfer_active ##1 !start_transfer) else $error("start");
    a_busy_cause: assert property ($rose(transfer_active)
        |-> start_transfer) else $error("busy");
    a_pat_clear: assert property (clear_channel_enable
        |-> !transfer_active) else $error("pattern");
    a_flag_sticky: assert property (channel_abort_flag && !flag_clr
        |=> channel_abort_flag) else $error("flag lost");
    a_ctrl_resv: assert property (reg_read && reg_addr == 4'h0
        |=> reg_rdata[31:24] == 8'h0 && reg_rdata[7:6] == 2'h0
        && reg_rdata[2:0] == 3'h0) else $error("reserved");
endmodule

// ---- tb/dcec_partner.sv ----
/* partner: request lines and channel engine beside the block.
   assumes the bench drives fire, num, pat and done on clk. */
`timescale 1ns/1ps
module dcec_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [7:0] num,
    input wire logic pat,
    input wire logic done,
    input wire logic clear_channel_enable,
    output logic [255:0] irq_lines,
    output logic pattern_match,
    output logic channel_enable,
    output logic transfer_done
);
    // engine finishes only when the bench says so
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_lines <= '0;
            pattern_match <= 1'b0;
            channel_enable <= 1'b1;
            transfer_done <= 1'b0;
        end else begin
            irq_lines <= fire ? 256'h1 << num : '0;
            pattern_match <= pat;
            transfer_done <= done;
            if (clear_channel_enable)
                channel_enable <= 1'b0;
        end
    end
endmodule

// ---- tb/dma_channel_event_control_tb_top.sv ----
/* bench top: register, trigger and interrupt scenarios.
   assumes the partner model on the request and engine side. */
`timescale 1ns/1ps
module dma_channel_event_control_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic fire = 1'b0;
    logic [7:0] num = 8'h0;
    logic pat = 1'b0;
    logic done = 1'b0;
    logic [255:0] irq_lines;
    logic pattern_match, channel_enable, transfer_done;
    logic [31:0] reg_rdata, rv;
    logic start_transfer, abort_transfer, clear_channel_enable;
    logic transfer_active, channel_abort_flag, irq;
    int num_errors = 0;
    int samples_checked = 0;
    initial forever #4 clk = ~clk;
    dcec_event_control dut_u (.*);
    dcec_partner partner_u (.*);
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic fire_irq(input logic [7:0] k);
        @(posedge clk);
        num <= k;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    // k: 0 start, 1 abort, 2 enable clear; e=0 means must stay quiet
    task automatic waitsig(input int k, input logic e);
        logic s;
        s = 1'b0;
        for (int i = 0; i < 12 && !s; i++) begin
            @(posedge clk);
            #1;
            s = k == 0 ? start_transfer : k == 1 ? abort_transfer
                : clear_channel_enable;
        end
        chk({31'h0, s}, {31'h0, e});
        if (e && !s)
            stop_test();
    endtask
    task automatic t_regs();
        rd(4'h0);
        chk(rv, 32'h00FFFF00);
        wr(4'h0, 32'hFFFFFF3F);
        rd(4'h0);
        chk(rv, 32'h00FFFF38);
        rd(4'hF);
        chk(rv, 32'h0);
        $display("regs done");
    endtask
    task automatic t_force();
        wr(4'h0, 32'h00000080);
        chk({30'h0, start_transfer, transfer_active}, 32'h3);
        rd(4'h0);
        chk(rv, 32'h0);
        wr(4'h0, 32'h00000040);
        chk({30'h0, abort_transfer, transfer_active}, 32'h2);
        wr(4'h0, 32'h000000C0);
        chk({30'h0, start_transfer, transfer_active}, 32'h0);
        $display("force done");
    endtask
    task automatic t_irq_start();
        wr(4'h0, 32'h00050310);
        fire_irq(8'h04);
        waitsig(0, 1'b0);
        fire_irq(8'h03);
        waitsig(0, 1'b1);
        wr(4'h0, 32'h00000040);
        wr(4'h0, 32'h00050300);
        fire_irq(8'h03);
        waitsig(0, 1'b0);
        $display("irq start done");
    endtask
    task automatic t_irq_abort();
        wr(4'h0, 32'h00050380);
        fire_irq(8'h05);
        waitsig(1, 1'b0);
        wr(4'h0, 32'h00050308);
        fire_irq(8'h05);
        waitsig(1, 1'b1);
        rd(4'h1);
        chk(rv, 32'h2);
        wr(4'h4, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(4'h4, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(4'h2);
        chk(rv, 32'h3);
        wr(4'h4, 32'h2);
        wr(4'h3, 32'h2);
        chk({30'h0, irq, channel_abort_flag}, 32'h0);
        $display("irq abort done");
    endtask
    task automatic t_done();
        wr(4'h0, 32'h00000080);
        chk({31'h0, transfer_active}, 32'h1);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
        #1;
        chk({31'h0, transfer_active}, 32'h0);
        $display("engine done done");
    endtask
    task automatic t_pattern();
        wr(4'h0, 32'h000000A0);
        @(posedge clk);
        pat <= 1'b1;
        @(posedge clk);
        pat <= 1'b0;
        waitsig(2, 1'b1);
        @(posedge clk);
        #1;
        chk({30'h0, channel_enable, transfer_active}, 32'h0);
        rd(4'h2);
        chk(rv, 32'h5);
        $display("pattern done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_force();
        t_irq_start();
        t_irq_abort();
        t_done();
        t_pattern();
        stop_test();
    end
endmodule
bind dcec_event_control dcec_checker chk_u (.*);
